// ==== src/sfm_defs.svh ====
`ifndef SFM_DEFS_SVH
`define SFM_DEFS_SVH
// Notes on behaviour
// [RULE_01] Every present line readable as digital input
// [RULE_02] Any present line can stop a motion
// [RULE_03] Kill on lines 1-3; all lines later
// [RULE_04] Line 1 triggers modulo output when present
// [RULE_05] Every present line drivable as program output
// [RULE_06] Only lines 4-7 may be analog inputs
// [RULE_07] Lines 1-3 may output raw encoder signals
// [RULE_08] Lines 4-6 buffer internal or external encoder
// [RULE_09] Lines 6-7 output scaled encoder, gated
// [RULE_10] External encoder accepted on lines 2-6
// [RULE_11] External count as feedback or master
// [RULE_12] Line 2 as 25kHz PWM, width per cycle
// [RULE_13] Line 1 done output, selectable active level
// [RULE_14] Line 1 position compare, single or cyclic
// [RULE_15] Lines 101+ only on expanded variants
// [RULE_16] Encoder-assigned line locked from other functions
// [RULE_17] Inputs sampled once per servo cycle
// [RULE_18] Reset makes every line a digital input

// ----------------------------------------------------------
// Timing
// ----------------------------------------------------------
`define SFM_CLK_PERIOD_NS   8
`define SFM_SERVO_CYCLE_NS  120000
`define SFM_PWM_FREQ_KHZ    25
`define SFM_PWM_PERIOD_NS   (1000000 / `SFM_PWM_FREQ_KHZ)
`define SFM_SERVO_CYC       (`SFM_SERVO_CYCLE_NS / `SFM_CLK_PERIOD_NS)
`define SFM_PWM_CYC         (`SFM_PWM_PERIOD_NS / `SFM_CLK_PERIOD_NS)

// ----------------------------------------------------------
// Line counts and line positions (index 0 is line 1)
// ----------------------------------------------------------
`define SFM_STD_LINES   7
`define SFM_EXP_LINES   16
`define SFM_ADC_BITS    10
`define SFM_LINE_DONE   0
`define SFM_LINE_PWM    1
`define SFM_KILL_HI     2
`define SFM_ENCOUT_HI   2
`define SFM_ANALOG_LO   3
`define SFM_ANALOG_HI   6
`define SFM_BUF_LO      3
`define SFM_BUF_HI      5
`define SFM_MODOUT_LO   5
`define SFM_MODOUT_HI   6
`define SFM_ENCIN_LO    1
`define SFM_ENCIN_HI    5
`define SFM_EXT_A       3
`define SFM_EXT_B       4
`define SFM_EXT_IDX     5
`define SFM_ALT_STEP    1
`define SFM_ALT_DIR     2
`endif

// ==== src/sfm_pkg.sv ====
package sfm_pkg;
   // Role of one I/O line
   typedef enum logic [3:0] {
      SFM_DIN, SFM_DOUT, SFM_AIN, SFM_ENC_OUT, SFM_ENC_BUF,
      SFM_MOD_TRIG, SFM_MOD_OUT, SFM_ENC_IN, SFM_PWM, SFM_DONE,
      SFM_PCMP
   } sfm_func_t;
endpackage

// ==== src/sfm_pwm.sv ====
`include "sfm_defs.svh"
module sfm_pwm
   import sfm_pkg::*;
#(
   parameter int PERIOD_CYC = `SFM_PWM_CYC,
   parameter int WB         = 13
) (
   input  wire logic          sys_clk,
   input  wire logic          arst_n,
   input  wire logic          tick,
   input  wire logic          enable,
   input  wire logic [WB-1:0] duty,
   output logic               pwmOut
);
   logic [WB-1:0] cnt;
   logic [WB-1:0] next_cnt;
   logic [WB-1:0] dutyHeld;
   logic [WB-1:0] next_dutyHeld;
   logic          next_pwmOut;

   // Free period counter, width taken once per servo cycle
   always_comb begin
      next_cnt      = (cnt == WB'(PERIOD_CYC - 1)) ? '0 : cnt + 1'b1;
      next_dutyHeld = tick ? duty : dutyHeld;          // RULE_12
      next_pwmOut   = enable && (cnt < dutyHeld);      // RULE_12
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt      <= '0;
         dutyHeld <= '0;
         pwmOut   <= 1'b0;
      end else begin
         cnt      <= next_cnt;
         dutyHeld <= next_dutyHeld;
         pwmOut   <= next_pwmOut;
      end
   end

   property p_pwm_duty_hold;
      @(posedge sys_clk) disable iff (!arst_n)
      !tick |=> $stable(dutyHeld);
   endproperty
   a_pwm_duty_hold: assert property (p_pwm_duty_hold) // RULE_12
      else $error("pwm width changed off the servo tick");

   property p_pwm_wrap;
      @(posedge sys_clk) disable iff (!arst_n)
      cnt == WB'(PERIOD_CYC - 1) |=> cnt == '0;
   endproperty
   a_pwm_wrap: assert property (p_pwm_wrap) // RULE_12
      else $error("pwm period counter did not wrap");
endmodule

// ==== src/sfm_function_mux.sv ====
`include "sfm_defs.svh"
module sfm_function_mux
   import sfm_pkg::*;
#(
   parameter int SERVO_CYC    = `SFM_SERVO_CYC,
   parameter int PWM_CYC      = `SFM_PWM_CYC,
   parameter bit HAS_EXPANDED = 1'b1,
   parameter bit HAS_MODULO   = 1'b1,
   parameter bit HAS_BUFFER   = 1'b1,
   parameter bit LATER_FW     = 1'b1,
   parameter int NL           = `SFM_STD_LINES + `SFM_EXP_LINES
) (
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic [6:0]  padIn,
   output logic      [6:0]  padOut,
   output logic      [6:0]  padOe,
   input  wire logic [15:0] expIn,
   output logic      [15:0] expOut,
   output logic      [15:0] expOe,
   input  wire logic        cfgWrite,
   input  wire logic [4:0]  cfgLine,
   input  wire sfm_func_t   cfgFunc,
   output logic             cfgAck,
   output logic             cfgReject,
   output logic      [22:0] lineState,
   input  wire logic [22:0] progOutVal,
   input  wire logic        stopArm,
   input  wire logic [4:0]  stopSel,
   input  wire logic        stopLevel,
   output logic             motionStop,
   input  wire logic [22:0] killMask,
   input  wire logic [22:0] killLevel,
   output logic             killMotor,
   input  wire logic [39:0] adcData,
   output logic      [39:0] analogVal,
   input  wire logic [2:0]  encInt,
   input  wire logic [2:0]  encExtSrc,
   input  wire logic        encoder_mux_cmd,
   input  wire logic [1:0]  modScaled,
   output logic             modGate,
   output logic      [2:0]  extEnc,
   input  wire logic        extAsFeedback,
   input  wire logic        extAsMaster,
   output logic      [2:0]  loopFeedback,
   output logic      [2:0]  gearMaster,
   input  wire logic [12:0] pwmDuty,
   input  wire logic        posErrOk,
   input  wire logic        seqDone,
   input  wire logic        done_active_high_cmd,
   input  wire logic        done_active_low_cmd,
   input  wire logic        position_compare_cmd,
   input  wire logic [31:0] cmpTarget,
   input  wire logic [31:0] cmpPeriod,
   input  wire logic        cmpCyclic,
   input  wire logic [31:0] position
);
   localparam int ADCB = `SFM_ADC_BITS;

   // ----------------------------------------------------------
   // Legality of a role on a line
   // ----------------------------------------------------------
   function automatic logic sfmLegal(input logic [4:0] ln,
                                     input sfm_func_t  fn);
      logic present;
      logic ok;
      present = (ln < 5'(`SFM_STD_LINES))
              || (HAS_EXPANDED && ln < 5'(NL));         // RULE_15
      unique case (fn)
         SFM_DIN, SFM_DOUT: ok = 1'b1;                  // RULE_01 RULE_05
         SFM_AIN:      ok = ln >= 5'(`SFM_ANALOG_LO)
                         && ln <= 5'(`SFM_ANALOG_HI);   // RULE_06
         SFM_ENC_OUT:  ok = HAS_MODULO
                         && ln <= 5'(`SFM_ENCOUT_HI);   // RULE_07
         SFM_ENC_BUF:  ok = HAS_BUFFER && ln >= 5'(`SFM_BUF_LO)
                         && ln <= 5'(`SFM_BUF_HI);      // RULE_08
         SFM_MOD_TRIG: ok = HAS_MODULO && ln == 5'(0);  // RULE_04
         SFM_MOD_OUT:  ok = HAS_MODULO && ln >= 5'(`SFM_MODOUT_LO)
                         && ln <= 5'(`SFM_MODOUT_HI);   // RULE_09
         SFM_ENC_IN:   ok = ln >= 5'(`SFM_ENCIN_LO)
                         && ln <= 5'(`SFM_ENCIN_HI);    // RULE_10
         SFM_PWM:      ok = LATER_FW
                         && ln == 5'(`SFM_LINE_PWM);    // RULE_12
         SFM_DONE, SFM_PCMP: ok = ln == 5'(`SFM_LINE_DONE);
         default:      ok = 1'b0;
      endcase
      return present && ok;
   endfunction

   function automatic logic sfmHighSpeed(input sfm_func_t fn);
      return fn == SFM_ENC_OUT || fn == SFM_ENC_BUF
          || fn == SFM_MOD_OUT || fn == SFM_ENC_IN;
   endfunction

   // ----------------------------------------------------------
   // Pin synchroniser and servo tick
   // ----------------------------------------------------------
   logic [22:0] syncA;
   logic [22:0] syncB;
   logic [15:0] servoCnt;
   logic [15:0] next_servoCnt;
   logic        tick;
   logic        next_tick;

   // Tick marks the last clock of each servo cycle
   always_comb begin
      next_tick     = servoCnt == 16'(SERVO_CYC - 2);
      next_servoCnt = (servoCnt == 16'(SERVO_CYC - 1)) ? '0
                    : servoCnt + 16'h0001;
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         syncA    <= '0;
         syncB    <= '0;
         servoCnt <= '0;
         tick     <= 1'b0;
      end else begin
         syncA    <= {expIn, padIn};
         syncB    <= syncA;
         servoCnt <= next_servoCnt;
         tick     <= next_tick;
      end
   end

   // ----------------------------------------------------------
   // Line configuration
   // ----------------------------------------------------------
   sfm_func_t lineFunc      [NL];
   sfm_func_t next_lineFunc [NL];
   logic      next_cfgAck;
   logic      next_cfgReject;
   logic      cfgLocked;

   // Store a role only if legal and the line is not held
   always_comb begin
      next_lineFunc  = lineFunc;
      cfgLocked      = 1'b0;
      next_cfgAck    = 1'b0;
      next_cfgReject = 1'b0;
      if (cfgLine < 5'(NL)) begin
         cfgLocked = sfmHighSpeed(lineFunc[cfgLine])
                  && cfgFunc != SFM_DIN
                  && cfgFunc != lineFunc[cfgLine];   // RULE_16
      end
      if (cfgWrite) begin
         if (sfmLegal(cfgLine, cfgFunc) && !cfgLocked) begin
            next_lineFunc[cfgLine] = cfgFunc;
            next_cfgAck            = 1'b1;
         end else begin
            next_cfgReject = 1'b1;                    // RULE_15 RULE_16
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < NL; i++) begin
            lineFunc[i] <= SFM_DIN;                   // RULE_18
         end
         cfgAck    <= 1'b0;
         cfgReject <= 1'b0;
      end else begin
         lineFunc  <= next_lineFunc;
         cfgAck    <= next_cfgAck;
         cfgReject <= next_cfgReject;
      end
   end

   // ----------------------------------------------------------
   // Sampled inputs, stop, kill, analog, modulo gate
   // ----------------------------------------------------------
   logic [22:0] killAllowed;
   logic [22:0] next_lineState;
   logic        next_motionStop;
   logic        next_killMotor;
   logic [39:0] next_analogVal;
   logic        next_modGate;
   logic        trigPrev;
   logic        next_trigPrev;

   assign killAllowed = LATER_FW ? '1 : 23'h000007;  // RULE_03

   // Levels move only on the servo tick
   always_comb begin
      next_lineState  = tick ? syncB : lineState;     // RULE_17 RULE_01
      next_motionStop = stopArm && stopSel < 5'(NL)
                     && lineState[stopSel] == stopLevel; // RULE_02
      next_killMotor  = |(killMask & killAllowed
                       & ~(lineState ^ killLevel));   // RULE_03
      next_analogVal  = analogVal;
      next_trigPrev   = trigPrev;
      next_modGate    = modGate;
      if (tick) begin
         for (int k = 0; k < 4; k++) begin
            next_analogVal[k*ADCB +: ADCB] =
               (lineFunc[`SFM_ANALOG_LO + k] == SFM_AIN)
               ? adcData[k*ADCB +: ADCB] : '0;        // RULE_06
         end
         next_trigPrev = syncB[0];
         if (lineFunc[0] == SFM_MOD_TRIG && syncB[0] && !trigPrev) begin
            next_modGate = !modGate;                  // RULE_04
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         lineState  <= '0;
         motionStop <= 1'b0;
         killMotor  <= 1'b0;
         analogVal  <= '0;
         trigPrev   <= 1'b0;
         modGate    <= 1'b0;
      end else begin
         lineState  <= next_lineState;
         motionStop <= next_motionStop;
         killMotor  <= next_killMotor;
         analogVal  <= next_analogVal;
         trigPrev   <= next_trigPrev;
         modGate    <= next_modGate;
      end
   end

   // ----------------------------------------------------------
   // External encoder, feedback, done and compare
   // ----------------------------------------------------------
   logic [2:0]  next_extEnc;
   logic        doneHigh;
   logic        next_doneHigh;
   logic        cmpArmed;
   logic        next_cmpArmed;
   logic        cmpHit;
   logic        next_cmpHit;
   logic        cmpRepeat;
   logic        next_cmpRepeat;
   logic [31:0] cmpAt;
   logic [31:0] next_cmpAt;
   logic        pwmLine;

   always_comb begin
      // Quadrature on 4/5, else step/direction on 2/3
      next_extEnc = '0;
      if (lineFunc[`SFM_EXT_A] == SFM_ENC_IN) begin
         next_extEnc[1:0] = {syncB[`SFM_EXT_B], syncB[`SFM_EXT_A]};
      end else if (lineFunc[`SFM_ALT_STEP] == SFM_ENC_IN) begin
         next_extEnc[1:0] = {syncB[`SFM_ALT_DIR], syncB[`SFM_ALT_STEP]};
      end                                             // RULE_10
      if (lineFunc[`SFM_EXT_IDX] == SFM_ENC_IN) begin
         next_extEnc[2] = syncB[`SFM_EXT_IDX];
      end
      next_doneHigh = doneHigh;
      if (done_active_high_cmd) begin
         next_doneHigh = 1'b1;                        // RULE_13
      end else if (done_active_low_cmd) begin
         next_doneHigh = 1'b0;
      end
      next_cmpArmed  = cmpArmed;
      next_cmpAt     = cmpAt;
      next_cmpRepeat = cmpRepeat;
      next_cmpHit    = tick ? 1'b0 : cmpHit;
      if (position_compare_cmd) begin
         next_cmpArmed  = 1'b1;
         next_cmpAt     = cmpTarget;
         next_cmpRepeat = cmpCyclic;
      end else if (tick && cmpArmed && $signed(position)
                   >= $signed(cmpAt)) begin
         next_cmpHit = 1'b1;                          // RULE_14
         if (cmpRepeat) begin
            next_cmpAt = cmpAt + cmpPeriod;
         end else begin
            next_cmpArmed = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         extEnc       <= '0;
         loopFeedback <= '0;
         gearMaster   <= '0;
         doneHigh     <= 1'b1;
         cmpArmed     <= 1'b0;
         cmpHit       <= 1'b0;
         cmpRepeat    <= 1'b0;
         cmpAt        <= '0;
      end else begin
         extEnc       <= next_extEnc;
         loopFeedback <= extAsFeedback ? extEnc : encInt; // RULE_11
         gearMaster   <= extAsMaster ? extEnc : encInt;   // RULE_11
         doneHigh     <= next_doneHigh;
         cmpArmed     <= next_cmpArmed;
         cmpHit       <= next_cmpHit;
         cmpRepeat    <= next_cmpRepeat;
         cmpAt        <= next_cmpAt;
      end
   end

   sfm_pwm #(.PERIOD_CYC(PWM_CYC), .WB(13)) uPwm (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .tick    (tick),
      .enable  (lineFunc[`SFM_LINE_PWM] == SFM_PWM),
      .duty    (pwmDuty),
      .pwmOut  (pwmLine)
   );

   // ----------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------
   logic [22:0] pinOut;
   logic [22:0] pinOe;
   logic [22:0] next_pinOut;
   logic [22:0] next_pinOe;
   logic [2:0]  bufSig;

   assign bufSig = encoder_mux_cmd ? encExtSrc : encInt; // RULE_08

   // Each line drives by its role; input roles release it
   always_comb begin
      next_pinOut = '0;
      next_pinOe  = '0;
      for (int i = 0; i < NL; i++) begin
         unique case (lineFunc[i])
            SFM_DOUT: begin
               next_pinOut[i] = progOutVal[i];        // RULE_05
               next_pinOe[i]  = 1'b1;
            end
            SFM_ENC_OUT: begin
               next_pinOut[i] = encInt[i % 3];        // RULE_07
               next_pinOe[i]  = 1'b1;
            end
            SFM_ENC_BUF: begin
               next_pinOut[i] = bufSig[i % 3];        // RULE_08
               next_pinOe[i]  = 1'b1;
            end
            SFM_MOD_OUT: begin
               next_pinOut[i] = modGate && modScaled[i % 2 == 1 ? 0 : 1];
               next_pinOe[i]  = 1'b1;                 // RULE_09
            end
            SFM_PWM: begin
               next_pinOut[i] = pwmLine;              // RULE_12
               next_pinOe[i]  = 1'b1;
            end
            SFM_DONE: begin
               next_pinOut[i] = (posErrOk && seqDone) == doneHigh;
               next_pinOe[i]  = 1'b1;                 // RULE_13
            end
            SFM_PCMP: begin
               next_pinOut[i] = cmpHit;               // RULE_14
               next_pinOe[i]  = 1'b1;
            end
            default: begin
               next_pinOut[i] = 1'b0;
               next_pinOe[i]  = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pinOut <= '0;
         pinOe  <= '0;
      end else begin
         pinOut <= next_pinOut;
         pinOe  <= next_pinOe;
      end
   end

   assign padOut = pinOut[6:0];
   assign padOe  = pinOe[6:0];
   assign expOut = pinOut[22:7];
   assign expOe  = pinOe[22:7];

   // ----------------------------------------------------------
   // Checks
   // ----------------------------------------------------------
   sequence s_expReq;
      cfgWrite && cfgLine >= 5'(`SFM_STD_LINES);
   endsequence
   sequence s_refused;
      cfgReject && !cfgAck;
   endsequence

   property p_exp_refuse;
      @(posedge sys_clk) disable iff (!arst_n)
      (s_expReq and !HAS_EXPANDED) |=> s_refused;
   endproperty
   a_exp_refuse: assert property (p_exp_refuse) // RULE_15
      else $error("expanded line taken on a plain variant");

   property p_analog_low;
      @(posedge sys_clk) disable iff (!arst_n)
      cfgWrite && cfgFunc == SFM_AIN && cfgLine < 5'(3) |=> s_refused;
   endproperty
   a_analog_low: assert property (p_analog_low) // RULE_06
      else $error("analog role taken on lines 1-3");

   property p_hs_lock;
      @(posedge sys_clk) disable iff (!arst_n)
      cfgWrite && lineFunc[3] == SFM_ENC_IN && cfgLine == 5'(3)
      && cfgFunc == SFM_DOUT |=> s_refused ##1 lineFunc[3] == SFM_ENC_IN;
   endproperty
   a_hs_lock: assert property (p_hs_lock) // RULE_16
      else $error("encoder line reassigned while held");

   property p_sample_rate;
      @(posedge sys_clk) disable iff (!arst_n)
      !tick |=> $stable(lineState);
   endproperty
   a_sample_rate: assert property (p_sample_rate) // RULE_17
      else $error("input levels moved between servo ticks");

   property p_done_level;
      @(posedge sys_clk) disable iff (!arst_n)
      lineFunc[0] == SFM_DONE && posErrOk && seqDone && doneHigh
      |=> padOe[0] && padOut[0];
   endproperty
   a_done_level: assert property (p_done_level) // RULE_13
      else $error("done output not asserted high");

   property p_dout;
      @(posedge sys_clk) disable iff (!arst_n)
      lineFunc[2] == SFM_DOUT |=> padOe[2] && padOut[2] == $past(progOutVal[2]);
   endproperty
   a_dout: assert property (p_dout) // RULE_05
      else $error("digital output does not follow program value");

   property p_cmp_tick;
      @(posedge sys_clk) disable iff (!arst_n)
      $rose(cmpHit) |-> $past(tick);
   endproperty
   a_cmp_tick: assert property (p_cmp_tick) // RULE_14
      else $error("compare output changed off the servo tick");

   property p_kill_old;
      @(posedge sys_clk) disable iff (!arst_n)
      !LATER_FW && (killMask & 23'h000007) == '0 |=> !killMotor;
   endproperty
   a_kill_old: assert property (p_kill_old) // RULE_03
      else $error("kill raised from a line above 3");

   property p_mod_gate;
      @(posedge sys_clk) disable iff (!arst_n)
      lineFunc[6] == SFM_MOD_OUT && !modGate |=> !padOut[6];
   endproperty
   a_mod_gate: assert property (p_mod_gate) // RULE_09
      else $error("modulo output driven while gated off");
endmodule

// ==== sim/sfm_io_partner.sv ====
// Switches and loads on the pin side of the I/O lines
module sfm_io_partner
   import sfm_pkg::*;
(
   input  wire logic [6:0]  padOut,
   input  wire logic [6:0]  padOe,
   input  wire logic [15:0] expOut,
   input  wire logic [15:0] expOe,
   input  wire logic [22:0] swLevel,
   output logic      [6:0]  padIn,
   output logic      [15:0] expIn
);
   timeunit 1ns;
   timeprecision 1ps;
   // Driven line reads back its own level, else the switch
   assign padIn = (padOe & padOut) | (~padOe & swLevel[6:0]);
   assign expIn = (expOe & expOut) | (~expOe & swLevel[22:7]);
endmodule

// ==== sim/servo_io_function_mux_tb.sv ====
module servo_io_function_mux_tb
   import sfm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, arst_n = 1'b0, cfgWrite = 1'b0;
   logic cfgAck, cfgReject, motionStop, killMotor, modGate;
   logic [4:0]  cfgLine = 5'h00, stopSel = 5'h00;
   sfm_func_t   cfgFunc = SFM_DIN;
   logic [6:0]  padIn, padOut, padOe;
   logic [15:0] expIn, expOut, expOe;
   logic [22:0] lineState, sw = 23'h0, pov = 23'h0;
   logic [22:0] killMask = 23'h0, killLevel = 23'h0;
   logic        stopArm = 1'b0, stopLevel = 1'b0;
   logic [39:0] adcData = 40'h0;
   logic [165:0] big = '0;
   logic [31:0] r = 32'h4F, lfsrNext;
   logic [2:0]  encInt = 3'h0, encExtSrc = 3'h0;
   logic [1:0]  modScaled = 2'h0;
   logic [12:0] pwmDuty = 13'h0;
   logic [31:0] cmpTarget = 32'h0, cmpPeriod = 32'h0, position = 32'h0;
   logic muxCmd = 1'b0, fb = 1'b0, ms = 1'b0, pe = 1'b0, sd = 1'b0;
   logic dh = 1'b0, dl = 1'b0, pc = 1'b0, cy = 1'b0;
   int fails = 0, tests_run = 0, role[23];
   // -------------------------------------------
   // Clock, free random stimulus
   // -------------------------------------------
   always #4 sys_clk = ~sys_clk;
   assign lfsrNext = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
   always @(posedge sys_clk) begin
      r <= lfsrNext;
      big <= {big[133:0], r};
      {adcData, encInt, encExtSrc, muxCmd, modScaled, fb, ms, pwmDuty, pe,
       sd, dh, dl, pc, cmpTarget, cmpPeriod, cy, position} <= big;
   end
   sfm_function_mux #(.SERVO_CYC(20), .PWM_CYC(10)) dut (
      .sys_clk(sys_clk), .arst_n(arst_n), .padIn(padIn), .padOut(padOut),
      .padOe(padOe), .expIn(expIn), .expOut(expOut), .expOe(expOe),
      .cfgWrite(cfgWrite), .cfgLine(cfgLine), .cfgFunc(cfgFunc),
      .cfgAck(cfgAck), .cfgReject(cfgReject), .lineState(lineState),
      .progOutVal(pov), .stopArm(stopArm), .stopSel(stopSel),
      .stopLevel(stopLevel), .motionStop(motionStop), .killMask(killMask),
      .killLevel(killLevel), .killMotor(killMotor), .adcData(adcData),
      .analogVal(), .encInt(encInt), .encExtSrc(encExtSrc),
      .encoder_mux_cmd(muxCmd), .modScaled(modScaled), .modGate(modGate),
      .extEnc(), .extAsFeedback(fb), .extAsMaster(ms), .loopFeedback(),
      .gearMaster(), .pwmDuty(pwmDuty), .posErrOk(pe), .seqDone(sd),
      .done_active_high_cmd(dh), .done_active_low_cmd(dl),
      .position_compare_cmd(pc), .cmpTarget(cmpTarget),
      .cmpPeriod(cmpPeriod), .cmpCyclic(cy), .position(position));
   sfm_io_partner pin (.padOut(padOut), .padOe(padOe), .expOut(expOut),
      .expOe(expOe), .swLevel(sw), .padIn(padIn), .expIn(expIn));
   // -------------------------------------------
   // Checking and the role model
   // -------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      if (fails == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   function automatic bit legal(int l, int f);
      if (l > 22) return 0;
      if (role[l] inside {3, 4, 6, 7} && f != 0 && f != role[l]) return 0;
      case (f)
         0, 1: return 1;
         2: return l inside {[3:6]};
         3: return l < 3;
         4: return l inside {[3:5]};
         5, 9, 10: return l == 0;
         6: return l inside {5, 6};
         7: return l inside {[1:5]};
         8: return l == 1;
         default: return 0;
      endcase
   endfunction
   task automatic cfg(int l, int f);
      logic [22:0] oe, dm;
      bit ok;
      ok = legal(l, f);
      @(posedge sys_clk);
      cfgWrite <= 1'b1;
      cfgLine <= l[4:0];
      cfgFunc <= sfm_func_t'(f);
      @(posedge sys_clk);
      cfgWrite <= 1'b0;
      #1 chk({cfgAck, cfgReject}, {ok, !ok});
      if (ok) role[l] = f;
      for (int i = 0; i < 23; i++) begin
         oe[i] = role[i] inside {1, 3, 4, 6, 8, 9, 10};
         dm[i] = role[i] == 1;
      end
      @(posedge sys_clk);
      #1 chk({expOe, padOe}, oe);
      chk({expOut, padOut} & dm, pov & dm);
   endtask
   // -------------------------------------------
   // Main sequence and watchdog
   // -------------------------------------------
   initial begin
      #200000 fails++;
      stop_test();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      #1 chk({expOe, padOe}, 23'h0);
      for (int k = 0; k < 4; k++) begin
         @(posedge sys_clk);
         sw <= r[22:0];
         killMask <= lfsrNext[22:0];
         killLevel <= ~r[22:0] ^ (23'h1 << k);
         stopArm <= 1'b1;
         stopSel <= 5'(k * 5);
         stopLevel <= r[k * 5];
         repeat (45) @(posedge sys_clk);
         #1 chk(lineState, sw);
         chk(motionStop, 1'b1);
         chk(killMotor, |(killMask & ~(sw ^ killLevel)));
      end
      pov <= r[22:0];
      cfg(0, 3);
      cfg(0, 1);
      cfg(0, 0);
      for (int f = 0; f < 11; f++) cfg(f + 1, f);
      repeat (60) cfg(int'(r[4:0]), int'(r[11:8]) % 11);
      stop_test();
   end
endmodule
